// ### core/safety_map.svh
// register map, field positions and timing figures of the safety monitor
`ifndef SAFETY_MAP_SVH
`define SAFETY_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STAT    12'h008
`define OFS_IRQ_MASK    12'h00c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_RESET_CMD  0
`define ST_ESTOP        0
`define ST_DOOR_OPEN    1
`define ST_DOOR_LATCH   2
`define ST_TEACH_LATCH  3
`define ST_TEACH_ACK    4
`define ST_CRIT_DOOR    5
`define ST_CRIT_STOP    6
`define ST_PROHIBIT     7
`define ST_RELEASE      8
`define IRQ_DOOR_OPEN   0
`define IRQ_ESTOP       1
`define IRQ_TEACH       2
`define IRQ_CRIT_DOOR   3
`define IRQ_CRIT_STOP   4
`define IRQ_W           5

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define IRQ_MASK_RST    5'h00
`define DISAGREE_MS     2000
`define CLK_HZ          20000000
`define MS_PER_S        1000

`endif

// ### core/safety_pkg.sv
// types shared by the safety input monitor
package safety_pkg;
  // gray path: stop -> armed -> run
  typedef enum logic [1:0] {
    STOP_HELD  = 2'b01,
    STOP_ARMED = 2'b11,
    STOP_RUN   = 2'b10
  } stop_state_t;
endpackage

// ### core/safety_input_monitor.sv
// safety input monitor: door, stop and latch inputs with an apb slave
//
// What this block does
// - door channels that disagree two seconds or longer flag critical error
// - stop channels that disagree two seconds or longer flag critical error
// - door open and teach mode each set their own latched flag
// - latch release open keeps flags; closing it clears them
// - teach latch cleared with door open still leaves operation prohibited
// - door latch clears only if door closed before release closes
// - teach latch clears only if selector in auto before release closes
// - release closure also acknowledges the change into teach mode
// - active stop, also at power up, lights indicator and reports it
// - stop state left only after switch release then reset command
// - door open holds program and prohibits operation
// - floating open inputs read as broken loops, no normal operation
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "safety_map.svh"

module safety_input_monitor #(
  parameter int unsigned DISAGREE_CYCLES =
    `DISAGREE_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned TMR_W = 26
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // safety contacts, high = contact closed
  input  wire logic        door_channel_one_a,
  input  wire logic        door_channel_two_a,
  input  wire logic        stop_loop_one_pos,
  input  wire logic        stop_loop_two_pos,
  input  wire logic        door_latch_clear_a,
  input  wire logic        door_latch_clear_b,
  input  wire logic        teach_selected,
  // safety outputs
  output logic             estop_indicator,
  output logic             operation_prohibited,
  output logic             program_hold,
  output logic             critical_error,
  output logic             irq
);
  import safety_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  localparam int NIN = 6;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] flt_q;

  assign raw = {teach_selected, door_latch_clear_a & door_latch_clear_b,
                stop_loop_two_pos, stop_loop_one_pos,
                door_channel_two_a, door_channel_one_a};

  // all-zero reset: unconnected contacts look open, so loops read broken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= '0;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          flt_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic door_a, door_b, stop_a, stop_b, release_closed, teach_mode;
  assign door_a         = flt_q[0];
  assign door_b         = flt_q[1];
  assign stop_a         = flt_q[2];
  assign stop_b         = flt_q[3];
  assign release_closed = flt_q[4];
  assign teach_mode     = flt_q[5];

  logic door_open, stop_pressed;
  assign door_open    = !(door_a && door_b);
  assign stop_pressed = !(stop_a && stop_b);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic        wr_en;
  logic        reset_cmd;
  logic [31:0] wdata;
  assign wr_en = psel && penable && pready && pwrite;
  assign wdata = pwdata;
  assign reset_cmd = wr_en && (paddr == `OFS_CTRL)
                     && wdata[`CTRL_RESET_CMD];

  // ----------------------------------------------------------------------
  // channel disagreement timers, pair 0 door, pair 1 stop
  // ----------------------------------------------------------------------
  logic [1:0]       mismatch;
  logic [1:0]       crit_q;
  logic [1:0]       crit_rise;
  logic [TMR_W-1:0] tmr_q [2];
  assign mismatch = {stop_a ^ stop_b, door_a ^ door_b};

  for (genvar p = 0; p < 2; p++) begin : g_pair
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tmr_q[p] <= '0;
      end else if (!mismatch[p]) begin
        tmr_q[p] <= '0;
      end else if (tmr_q[p] != TMR_W'(DISAGREE_CYCLES)) begin
        tmr_q[p] <= tmr_q[p] + 1'b1;
      end
    end

    assign crit_rise[p] = mismatch[p] && !crit_q[p] &&
      (tmr_q[p] == TMR_W'(DISAGREE_CYCLES - 1));

    // error stays until a reset command while the pair agrees
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        crit_q[p] <= 1'b0;
      end else if (crit_rise[p]) begin
        crit_q[p] <= 1'b1;
      end else if (reset_cmd && !mismatch[p]) begin
        crit_q[p] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // latch release edge
  // ----------------------------------------------------------------------
  logic release_q;
  logic release_close;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_q <= 1'b0;
    end else begin
      release_q <= release_closed;
    end
  end
  assign release_close = release_closed && !release_q;

  // ----------------------------------------------------------------------
  // door and teach latches
  // ----------------------------------------------------------------------
  logic door_latch_q, teach_latch_q, teach_ack_q;

  // set wins over clear; a closed release only clears on its closing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      door_latch_q <= 1'b1;
    end else if (door_open) begin
      door_latch_q <= 1'b1;
    end else if (release_close) begin
      door_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      teach_latch_q <= 1'b0;
    end else if (teach_mode) begin
      teach_latch_q <= 1'b1;
    end else if (release_close) begin
      teach_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      teach_ack_q <= 1'b0;
    end else if (!teach_mode) begin
      teach_ack_q <= 1'b0;
    end else if (release_close) begin
      teach_ack_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // emergency stop state
  // ----------------------------------------------------------------------
  stop_state_t stop_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= STOP_HELD;
    end else begin
      case (stop_q)
        STOP_HELD: begin
          if (!stop_pressed) begin
            stop_q <= STOP_ARMED;
          end
        end
        STOP_ARMED: begin
          if (stop_pressed) begin
            stop_q <= STOP_HELD;
          end else if (reset_cmd) begin
            stop_q <= STOP_RUN;
          end
        end
        STOP_RUN: begin
          if (stop_pressed) begin
            stop_q <= STOP_HELD;
          end
        end
        default: stop_q <= STOP_HELD;
      endcase
    end
  end

  logic estop_active;
  assign estop_active = (stop_q != STOP_RUN);

  // ----------------------------------------------------------------------
  // safety outputs
  // ----------------------------------------------------------------------
  logic prohibit;
  // teach latch alone does not prohibit; an open door still does
  assign prohibit = estop_active || door_open || door_latch_q ||
                    (|crit_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_indicator      <= 1'b1;
      operation_prohibited <= 1'b1;
      program_hold         <= 1'b1;
      critical_error       <= 1'b0;
    end else begin
      estop_indicator      <= estop_active;
      operation_prohibited <= prohibit;
      program_hold         <= door_open;
      critical_error       <= |crit_q;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic              door_open_q;
  logic              estop_q;
  logic              teach_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      door_open_q <= 1'b1;
      estop_q     <= 1'b1;
      teach_q     <= 1'b0;
    end else begin
      door_open_q <= door_open;
      estop_q     <= estop_active;
      teach_q     <= teach_latch_q;
    end
  end

  always_comb begin
    irq_ev                 = '0;
    irq_ev[`IRQ_DOOR_OPEN] = door_open && !door_open_q;
    irq_ev[`IRQ_ESTOP]     = estop_active && !estop_q;
    irq_ev[`IRQ_TEACH]     = teach_latch_q && !teach_q;
    irq_ev[`IRQ_CRIT_DOOR] = crit_rise[0];
    irq_ev[`IRQ_CRIT_STOP] = crit_rise[1];
  end

  // an event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr_en && paddr == `OFS_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~wdata[`IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `IRQ_MASK_RST;
    end else if (wr_en && paddr == `OFS_IRQ_MASK) begin
      irq_mask_q <= wdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // apb read path, no wait state
  // ----------------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_d;
  logic        mapped;

  always_comb begin
    status_word                  = '0;
    status_word[`ST_ESTOP]       = estop_active;
    status_word[`ST_DOOR_OPEN]   = door_open;
    status_word[`ST_DOOR_LATCH]  = door_latch_q;
    status_word[`ST_TEACH_LATCH] = teach_latch_q;
    status_word[`ST_TEACH_ACK]   = teach_ack_q;
    status_word[`ST_CRIT_DOOR]   = crit_q[0];
    status_word[`ST_CRIT_STOP]   = crit_q[1];
    status_word[`ST_PROHIBIT]    = prohibit;
    status_word[`ST_RELEASE]     = release_closed;
  end

  always_comb begin
    rd_d   = '0;
    mapped = 1'b1;
    case (paddr)
      `OFS_CTRL:     rd_d = '0;
      `OFS_STATUS:   rd_d = status_word;
      `OFS_IRQ_STAT: rd_d = {{(32-`IRQ_W){1'b0}}, irq_stat_q};
      `OFS_IRQ_MASK: rd_d = {{(32-`IRQ_W){1'b0}}, irq_mask_q};
      default:       mapped = 1'b0;
    endcase
  end

  // data captured in setup, presented with pready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

endmodule // safety_input_monitor

`default_nettype wire

// ### dv/safety_monitor.sv
// port-level checker of the safety input monitor
`timescale 1ns/1ps
`default_nettype none
`include "safety_map.svh"
module safety_monitor #(
  parameter int unsigned DISAGREE_CYCLES = 20
) (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // contacts and safety outputs
  input wire logic        door_channel_one_a,
  input wire logic        door_channel_two_a,
  input wire logic        stop_loop_one_pos,
  input wire logic        stop_loop_two_pos,
  input wire logic        estop_indicator,
  input wire logic        operation_prohibited,
  input wire logic        program_hold,
  input wire logic        critical_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned run_d_q;
  int unsigned run_s_q;
  logic        long_q;
  logic        ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite &&
                   paddr == `OFS_CTRL && pwdata[`CTRL_RESET_CMD];
  // raw disagreement run lengths; margin covers the input filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_q <= 0;
      run_s_q <= 0;
      long_q  <= 1'b0;
    end else begin
      run_d_q <= (door_channel_one_a != door_channel_two_a) ? run_d_q + 1 : 0;
      run_s_q <= (stop_loop_one_pos != stop_loop_two_pos) ? run_s_q + 1 : 0;
      // a long run arms one rise; a raised error disarms it again
      if (run_d_q + 4 >= DISAGREE_CYCLES ||
          run_s_q + 4 >= DISAGREE_CYCLES) begin
        long_q <= 1'b1;
      end else if (critical_error) begin
        long_q <= 1'b0;
      end
    end
  end
  sequence setup_s; psel && !penable; endsequence
  sequence door_open_s; (!door_channel_one_a) [*7]; endsequence
  sequence stop_press_s; (!stop_loop_one_pos) [*7]; endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  door_hold_a: assert property (door_open_s |=> program_hold)
    else $error("open door did not hold program");
  door_prohibit_a: assert property (
    door_open_s |=> operation_prohibited)
    else $error("open door did not prohibit operation");
  stop_lamp_a: assert property (stop_press_s |=> estop_indicator)
    else $error("stop pressed but lamp off");
  door_crit_a: assert property (
    run_d_q >= DISAGREE_CYCLES + 8 |-> critical_error)
    else $error("door disagreement not flagged");
  stop_crit_a: assert property (
    run_s_q >= DISAGREE_CYCLES + 8 |-> critical_error)
    else $error("stop disagreement not flagged");
  crit_timer_a: assert property ($rose(critical_error) |-> long_q)
    else $error("error flagged on a short disagreement");
  stop_exit_a: assert property (
    $fell(estop_indicator) |-> $past(stop_loop_one_pos, 5) &&
    $past(stop_loop_two_pos, 5) &&
    ($past(ctrl_wr, 1) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3)))
    else $error("stop left without release and reset command");
endmodule // safety_monitor
bind safety_input_monitor safety_monitor #(
  .DISAGREE_CYCLES(DISAGREE_CYCLES)
) i_safety_monitor (.*);
`default_nettype wire

// ### dv/contact_model.sv
// model of the external door, stop, latch release and selector switches
`timescale 1ns/1ps
`default_nettype none
module contact_model (
  // switch positions
  input  wire logic door_closed,
  input  wire logic stop_released,
  input  wire logic release_closed,
  input  wire logic teach_mode,
  // faults: one channel broken, or connector left empty
  input  wire logic skew_door,
  input  wire logic skew_stop,
  input  wire logic unplugged,
  // contact levels, 1 = closed
  output logic      door_channel_one_a,
  output logic      door_channel_two_a,
  output logic      stop_loop_one_pos,
  output logic      stop_loop_two_pos,
  output logic      door_latch_clear_a,
  output logic      door_latch_clear_b,
  output logic      teach_selected
);
  // an empty connector floats open, which reads as a broken loop
  assign door_channel_one_a = !unplugged && door_closed;
  assign door_channel_two_a = !unplugged && (door_closed ^ skew_door);
  assign stop_loop_one_pos  = !unplugged && stop_released;
  assign stop_loop_two_pos  =
    !unplugged && (stop_released ^ skew_stop);
  assign door_latch_clear_a = !unplugged && release_closed;
  assign door_latch_clear_b = !unplugged && release_closed;
  assign teach_selected     = teach_mode;
endmodule // contact_model
`default_nettype wire

// ### dv/safety_input_monitor_test.sv
// self-checking bench of the safety input monitor
`timescale 1ns/1ps
`default_nettype none
`include "safety_map.svh"
module safety_input_monitor_test;
  localparam int unsigned DC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic estop_indicator, operation_prohibited, program_hold;
  logic critical_error, irq;
  logic door_closed, stop_released, release_closed, teach_mode;
  logic skew_door, skew_stop, unplugged;
  wire logic door_channel_one_a, door_channel_two_a, stop_loop_one_pos;
  wire logic stop_loop_two_pos, door_latch_clear_a, door_latch_clear_b;
  wire logic teach_selected;
  int n_errors, n_checks;
  safety_input_monitor #(.DISAGREE_CYCLES(DC)) i_safety_input_monitor (.*);
  contact_model i_contact_model (.*);
  task automatic chk(input string n, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    s = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st;
    apb(1'b0, `OFS_STATUS, 32'h0);
  endtask
  task automatic cmd;
    apb(1'b1, `OFS_CTRL, 32'h1);
    tick(3);
  endtask
  task automatic set_rel(input logic v);
    @(posedge pclk);
    release_closed <= v;
    tick(8);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_power;
    tick(8);
    st;
    chk("stop status", s[`ST_ESTOP], 1'b1);
    chk("lamp", estop_indicator, 1'b1);
    chk("door latch", s[`ST_DOOR_LATCH], 1'b1);
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk("mask reset", s, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", s, 32'h0);
    $display("done power");
  endtask
  task automatic t_stop;
    cmd;
    chk("cmd while pressed", estop_indicator, 1'b1);
    stop_released <= 1'b1;
    tick(8);
    chk("released no cmd", estop_indicator, 1'b1);
    cmd;
    chk("lamp off", estop_indicator, 1'b0);
    $display("done stop");
  endtask
  task automatic t_door;
    chk("hold", program_hold, 1'b1);
    set_rel(1'b1);
    st;
    chk("release with door open", s[`ST_DOOR_LATCH], 1'b1);
    set_rel(1'b0);
    door_closed <= 1'b1;
    tick(8);
    st;
    chk("latch kept", s[`ST_DOOR_LATCH], 1'b1);
    chk("hold off", program_hold, 1'b0);
    set_rel(1'b1);
    st;
    chk("latch cleared", s[`ST_DOOR_LATCH], 1'b0);
    chk("run allowed", operation_prohibited, 1'b0);
    set_rel(1'b0);
    $display("done door");
  endtask
  task automatic t_teach;
    apb(1'b1, `OFS_IRQ_MASK, 32'h1 << `IRQ_TEACH);
    tick(2);
    chk("masked irq", irq, 1'b0);
    teach_mode <= 1'b1;
    tick(8);
    st;
    chk("teach latch", s[`ST_TEACH_LATCH], 1'b1);
    chk("irq up", irq, 1'b1);
    apb(1'b1, `OFS_IRQ_STAT, 32'h1 << `IRQ_TEACH);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    set_rel(1'b1);
    st;
    chk("teach ack", s[`ST_TEACH_ACK], 1'b1);
    chk("latch in teach", s[`ST_TEACH_LATCH], 1'b1);
    set_rel(1'b0);
    teach_mode <= 1'b0;
    door_closed <= 1'b0;
    tick(8);
    set_rel(1'b1);
    st;
    chk("teach cleared", s[`ST_TEACH_LATCH], 1'b0);
    chk("door still prohibits", operation_prohibited, 1'b1);
    set_rel(1'b0);
    door_closed <= 1'b1;
    tick(8);
    set_rel(1'b1);
    set_rel(1'b0);
    $display("done teach");
  endtask
  task automatic t_crit;
    logic [31:0] ev;
    repeat (2) begin
      skew_door <= 1'b1;
      tick(DC - 8);
      skew_door <= 1'b0;
      tick(6);
    end
    tick(6);
    chk("short skew", critical_error, 1'b0);
    skew_door <= 1'b1;
    tick(DC + 12);
    chk("door crit", critical_error, 1'b1);
    skew_door <= 1'b0;
    tick(8);
    cmd;
    chk("crit clear", critical_error, 1'b0);
    skew_stop <= 1'b1;
    tick(DC + 12);
    st;
    chk("stop crit", s[`ST_CRIT_STOP], 1'b1);
    skew_stop <= 1'b0;
    tick(8);
    cmd;
    chk("stop crit clear", critical_error, 1'b0);
    chk("lamp off again", estop_indicator, 1'b0);
    // door opened, stop entered and both pair errors are still pending
    ev = (32'h1 << `IRQ_DOOR_OPEN) | (32'h1 << `IRQ_ESTOP) |
         (32'h1 << `IRQ_CRIT_DOOR) | (32'h1 << `IRQ_CRIT_STOP);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("irq events", s, ev);
    apb(1'b1, `OFS_IRQ_STAT, ev);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("irq cleared all", s, 32'h0);
    $display("done crit");
  endtask
  task automatic t_unplug;
    unplugged <= 1'b1;
    tick(8);
    chk("unplugged stop", estop_indicator, 1'b1);
    chk("unplugged prohibit", operation_prohibited, 1'b1);
    $display("done unplug");
  endtask
  // ----------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(50 * 20000);
    n_errors++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {door_closed, stop_released, release_closed, teach_mode} = '0;
    {skew_door, skew_stop, unplugged} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_power();
    t_stop();
    t_door();
    t_teach();
    t_crit();
    t_unplug();
    test_done();
  end
endmodule // safety_input_monitor_test
`default_nettype wire
